//--- hdl/alu_flag_pkg.sv
`default_nettype none
package alu_flag_pkg;
    // Register map (byte addresses on the register bus)
    localparam logic [7:0] FLAG_REG_OFFSET  = 8'h00;
    localparam logic [7:0] OP_A_OFFSET      = 8'h04;
    localparam logic [7:0] OP_B_OFFSET      = 8'h08;
    localparam logic [7:0] CMD_OFFSET       = 8'h0c;
    localparam logic [7:0] RESULT_OFFSET    = 8'h10;

    // Flag field positions
    localparam int TOP_BIT_OUT_POS  = 0;
    localparam int NIBBLE_CARRY_POS = 1;
    localparam int RESULT_NIL_POS   = 2;
    localparam int SIGNED_WRAP_POS  = 3;
    localparam int IS_BELOW_ZERO_POS = 4;
    localparam logic [7:0] FLAG_IMPL_MASK = 8'h1f;
    localparam logic [7:0] FLAG_RESET     = 8'h00;

    // Command field: [3:0] operation, [4] destination is the flag register
    localparam int CMD_DEST_FLAG_POS = 4;

    typedef enum logic [3:0] {
        add_w_file_op        = 4'h0,
        add_literal_op       = 4'h1,
        literal_minus_w_op   = 4'h2,
        file_minus_w_op      = 4'h3,
        and_op               = 4'h4,
        or_op                = 4'h5,
        xor_op               = 4'h6,
        clear_file_op        = 4'h7,
        bit_clear_op         = 4'h8,
        bit_set_op           = 4'h9,
        nibble_swap_op       = 4'ha,
        file_to_file_move_op = 4'hb,
        w_to_file_move_op    = 4'hc
    } alu_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_RESP = 2'b10
    } bus_state_t;
endpackage
`default_nettype wire

//--- hdl/alu_flag_core.sv
`default_nettype none
module alu_flag_core (
    input  wire logic [3:0] op_in,
    input  wire logic [7:0] a_in,
    input  wire logic [7:0] w_in,
    input  wire logic [2:0] bit_sel_in,
    output logic      [7:0] result_out,
    output logic            writes_flags_out,
    output logic            carry_valid_out,
    output logic            carry_out,
    output logic            nibble_carry_out,
    output logic            wrap_valid_out,
    output logic            wrap_out
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] x;
    logic [7:0] y;
    logic       cin;

    always_comb begin
        x   = a_in;
        y   = w_in;
        cin = 1'b0;
        // Subtraction is addition of the two's complement, so carry reads as not-borrow
        case (op_in)
            alu_flag_pkg::literal_minus_w_op,
            alu_flag_pkg::file_minus_w_op: begin
                y   = ~w_in;
                cin = 1'b1; // see (RQ5)
            end
            default: begin
                y   = w_in;
                cin = 1'b0;
            end
        endcase
    end

    assign sum = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    assign nib = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};

    always_comb begin
        result_out       = 8'h00;
        writes_flags_out = 1'b1;
        carry_valid_out  = 1'b0;
        wrap_valid_out   = 1'b0;
        case (op_in)
            alu_flag_pkg::add_w_file_op, alu_flag_pkg::add_literal_op,
            alu_flag_pkg::literal_minus_w_op, alu_flag_pkg::file_minus_w_op: begin
                result_out      = sum[7:0];
                carry_valid_out = 1'b1;
                wrap_valid_out  = 1'b1;
            end
            alu_flag_pkg::and_op:         result_out = a_in & w_in;
            alu_flag_pkg::or_op:          result_out = a_in | w_in;
            alu_flag_pkg::xor_op:         result_out = a_in ^ w_in;
            alu_flag_pkg::clear_file_op:  result_out = 8'h00;
            alu_flag_pkg::bit_clear_op: begin
                result_out       = a_in & ~(8'h01 << bit_sel_in);
                writes_flags_out = 1'b0;
            end
            alu_flag_pkg::bit_set_op: begin
                result_out       = a_in | (8'h01 << bit_sel_in);
                writes_flags_out = 1'b0;
            end
            alu_flag_pkg::nibble_swap_op: begin
                result_out       = {a_in[3:0], a_in[7:4]};
                writes_flags_out = 1'b0;
            end
            alu_flag_pkg::file_to_file_move_op: begin
                result_out       = a_in;
                writes_flags_out = 1'b0;
            end
            alu_flag_pkg::w_to_file_move_op: begin
                result_out       = w_in;
                writes_flags_out = 1'b0;
            end
            default: begin
                result_out       = 8'h00;
                writes_flags_out = 1'b0;
            end
        endcase
    end

    assign carry_out        = sum[8];                           // see (RQ9)
    assign nibble_carry_out = nib[4];                           // see (RQ8)
    // Sign of result differs from both operand signs when they agree
    assign wrap_out         = (x[7] == y[7]) && (sum[7] != x[7]); // see (RQ6)
endmodule
`default_nettype wire

//--- hdl/alu_status_flag_logic.sv
// Contract
// (RQ1) Flag register is a normal operand: readable, writable, usable as source or destination.
// (RQ2) Flag-affecting op targeting flag register drops result, updates flags instead.
// (RQ3) Clearing the flag register sets only the zero flag, others kept.
// (RQ4) Software should alter flags only with bit, swap or move instructions.
// (RQ5) In subtraction, carry flags mean not-borrow and not-digit-borrow.
// (RQ6) Overflow flag set when signed result changes sign bit wrongly, else cleared.
// (RQ7) Zero flag set on zero result, cleared on nonzero result.
// (RQ8) Digit carry set on carry out of bit 3 for add/subtract ops.
// (RQ9) Carry set on carry out of bit 7 for add/subtract ops.
// (RQ10) Negative flag copies result bit 7 of flag-affecting ops; clear_file_op keeps the old value.
// (RQ11) Upper three bits read zero and ignore writes; five flags read/write.
//
// Added by the designer: the address map and the AXI4-Lite register port.
`default_nettype none
module alu_status_flag_logic (
    input  wire logic        clk_in,
    input  wire logic        srst_in,
    input  wire logic [7:0]  s_axi_awaddr_in,
    input  wire logic        s_axi_awvalid_in,
    output logic             s_axi_awready_out,
    input  wire logic [31:0] s_axi_wdata_in,
    input  wire logic [3:0]  s_axi_wstrb_in,
    input  wire logic        s_axi_wvalid_in,
    output logic             s_axi_wready_out,
    output logic [1:0]       s_axi_bresp_out,
    output logic             s_axi_bvalid_out,
    input  wire logic        s_axi_bready_in,
    input  wire logic [7:0]  s_axi_araddr_in,
    input  wire logic        s_axi_arvalid_in,
    output logic             s_axi_arready_out,
    output logic [31:0]      s_axi_rdata_out,
    output logic [1:0]       s_axi_rresp_out,
    output logic             s_axi_rvalid_out,
    input  wire logic        s_axi_rready_in,
    output logic [7:0]       flags_out
);
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    logic [7:0]  flag_ff;
    logic [7:0]  op_a_ff;
    logic [7:0]  op_b_ff;
    logic [7:0]  result_ff;
    logic [7:0]  aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0]  w_strb_ff;
    logic        aw_held_ff;
    logic        w_held_ff;
    logic        bvalid_ff;
    logic [1:0]  bresp_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;

    logic        wr_go;
    logic        cmd_go;
    logic [3:0]  cmd_op;
    logic        cmd_dest_flag;
    logic [7:0]  alu_res;
    logic        alu_wflags;
    logic        alu_cvalid;
    logic        alu_c;
    logic        alu_dc;
    logic        alu_ovvalid;
    logic        alu_ov;
    logic [7:0]  nxt_flag;
    logic [7:0]  src_a;
    logic        op_known;

    assign wr_go         = aw_held_ff && w_held_ff && !bvalid_ff;
    // Op codes beyond the last defined one are ignored entirely
    assign op_known      = cmd_op <= alu_flag_pkg::w_to_file_move_op;
    assign cmd_go        = wr_go && (aw_addr_ff == alu_flag_pkg::CMD_OFFSET) && w_strb_ff[0] && op_known;
    assign cmd_op        = w_data_ff[3:0];
    assign cmd_dest_flag = w_data_ff[alu_flag_pkg::CMD_DEST_FLAG_POS];
    // Flag register can be the source operand as well
    assign src_a         = cmd_dest_flag ? flag_ff : op_a_ff; // see (RQ1)

    // Combinational ALU; its side outputs pick which flags an op updates
    alu_flag_core u_alu_flag_core (
        .op_in            (cmd_op),
        .a_in             (src_a),
        .w_in             (op_b_ff),
        .bit_sel_in       (w_data_ff[10:8]),
        .result_out       (alu_res),
        .writes_flags_out (alu_wflags),
        .carry_valid_out  (alu_cvalid),
        .carry_out        (alu_c),
        .nibble_carry_out (alu_dc),
        .wrap_valid_out   (alu_ovvalid),
        .wrap_out         (alu_ov)
    );

    always_comb begin
        nxt_flag = flag_ff;
        if (cmd_go) begin
            if (alu_wflags) begin
                // Flag update replaces any write of the result to the flag register
                nxt_flag[alu_flag_pkg::RESULT_NIL_POS]    = (alu_res == 8'h00); // see (RQ7) see (RQ3) see (RQ2)
                nxt_flag[alu_flag_pkg::IS_BELOW_ZERO_POS] = alu_res[7];        // see (RQ10)
                if (alu_cvalid) begin
                    nxt_flag[alu_flag_pkg::TOP_BIT_OUT_POS]  = alu_c;  // see (RQ9)
                    nxt_flag[alu_flag_pkg::NIBBLE_CARRY_POS] = alu_dc; // see (RQ8)
                end
                if (alu_ovvalid) begin
                    nxt_flag[alu_flag_pkg::SIGNED_WRAP_POS] = alu_ov; // see (RQ6)
                end
                if (cmd_op == alu_flag_pkg::clear_file_op) begin
                    nxt_flag[alu_flag_pkg::IS_BELOW_ZERO_POS] = flag_ff[alu_flag_pkg::IS_BELOW_ZERO_POS]; // see (RQ3)
                end
            end else if (cmd_dest_flag) begin
                nxt_flag = alu_res; // see (RQ1)
            end
        end else if (wr_go && (aw_addr_ff == alu_flag_pkg::FLAG_REG_OFFSET) && w_strb_ff[0]) begin
            nxt_flag = w_data_ff[7:0]; // see (RQ1)
        end
        // Unimplemented upper bits always read zero
        nxt_flag = nxt_flag & alu_flag_pkg::FLAG_IMPL_MASK; // see (RQ11)
    end

    // Flag register starts from a fixed value so the first read is defined
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            flag_ff <= alu_flag_pkg::FLAG_RESET;
        end else begin
            flag_ff <= nxt_flag;
        end
    end

    // Operands and the last result of a command aimed elsewhere
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            op_a_ff   <= 8'h00;
            op_b_ff   <= 8'h00;
            result_ff <= 8'h00;
        end else if (wr_go && w_strb_ff[0]) begin
            if (aw_addr_ff == alu_flag_pkg::OP_A_OFFSET) begin
                op_a_ff <= w_data_ff[7:0];
            end
            if (aw_addr_ff == alu_flag_pkg::OP_B_OFFSET) begin
                op_b_ff <= w_data_ff[7:0];
            end
            if (cmd_go && !cmd_dest_flag) begin
                result_ff <= alu_res; // see (RQ2)
            end
        end
    end

    // Write address and data are captured independently, in either order
    assign s_axi_awready_out = !aw_held_ff;
    assign s_axi_wready_out  = !w_held_ff;

    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            aw_held_ff <= 1'b0;
            w_held_ff  <= 1'b0;
            aw_addr_ff <= 8'h00;
            w_data_ff  <= 32'h0000_0000;
            w_strb_ff  <= 4'h0;
            bvalid_ff  <= 1'b0;
            bresp_ff   <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid_in && !aw_held_ff) begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in && !w_held_ff) begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata_in;
                w_strb_ff <= s_axi_wstrb_in;
            end
            if (wr_go) begin
                bvalid_ff <= 1'b1;
                case (aw_addr_ff)
                    alu_flag_pkg::FLAG_REG_OFFSET, alu_flag_pkg::OP_A_OFFSET,
                    alu_flag_pkg::OP_B_OFFSET, alu_flag_pkg::CMD_OFFSET: bresp_ff <= RESP_OKAY;
                    default: bresp_ff <= RESP_SLVERR;
                endcase
            end else if (bvalid_ff && s_axi_bready_in) begin
                bvalid_ff  <= 1'b0;
                aw_held_ff <= 1'b0;
                w_held_ff  <= 1'b0;
            end
        end
    end

    // Write response stays up until bready; a new write waits for it
    assign s_axi_bvalid_out  = bvalid_ff;
    assign s_axi_bresp_out   = bresp_ff;
    // A new read address is accepted only once the previous data is taken
    assign s_axi_arready_out = !rvalid_ff;

    // Read data is captured when the address is taken and held until rready
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= RESP_OKAY;
        end else if (s_axi_arvalid_in && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff  <= RESP_OKAY;
            case (s_axi_araddr_in)
                alu_flag_pkg::FLAG_REG_OFFSET: rdata_ff <= {24'h000000, flag_ff}; // see (RQ11)
                alu_flag_pkg::OP_A_OFFSET:     rdata_ff <= {24'h000000, op_a_ff};
                alu_flag_pkg::OP_B_OFFSET:     rdata_ff <= {24'h000000, op_b_ff};
                alu_flag_pkg::CMD_OFFSET:      rdata_ff <= 32'h0000_0000;
                alu_flag_pkg::RESULT_OFFSET:   rdata_ff <= {24'h000000, result_ff};
                default: begin
                    rdata_ff <= 32'h0000_0000;
                    rresp_ff <= RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready_in) begin
            rvalid_ff <= 1'b0;
        end
    end

    assign s_axi_rvalid_out = rvalid_ff;
    assign s_axi_rdata_out  = rdata_ff;
    assign s_axi_rresp_out  = rresp_ff;
    assign flags_out        = flag_ff;
endmodule
`default_nettype wire

//--- dv/alu_status_flag_checker.sv
`default_nettype none
module alu_status_flag_checker (
    input wire logic        clk_in,
    input wire logic        srst_in,
    input wire logic [7:0]  s_axi_awaddr_in,
    input wire logic        s_axi_awvalid_in,
    input wire logic        s_axi_awready_out,
    input wire logic [31:0] s_axi_wdata_in,
    input wire logic [3:0]  s_axi_wstrb_in,
    input wire logic        s_axi_wvalid_in,
    input wire logic        s_axi_wready_out,
    input wire logic [1:0]  s_axi_bresp_out,
    input wire logic        s_axi_bvalid_out,
    input wire logic [7:0]  s_axi_araddr_in,
    input wire logic        s_axi_arready_out,
    input wire logic [31:0] s_axi_rdata_out,
    input wire logic        s_axi_rvalid_out,
    input wire logic [7:0]  flags_out
);
    logic [7:0] aw_ff;
    logic [5:0] wd_ff;
    logic       aw_bad;
    logic       aw_rw;
    // Captured write address, low five data bits and byte-0 strobe, checked when the response rises
    always_ff @(posedge clk_in) begin
        if (s_axi_awvalid_in && s_axi_awready_out)
            aw_ff <= s_axi_awaddr_in;
        if (s_axi_wvalid_in && s_axi_wready_out)
            wd_ff <= {s_axi_wstrb_in[0], s_axi_wdata_in[4:0]};
    end
    assign aw_bad = aw_ff[1:0] != 2'b00 || aw_ff > alu_flag_pkg::RESULT_OFFSET;
    assign aw_rw  = !aw_bad && aw_ff != alu_flag_pkg::RESULT_OFFSET;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);
    property p_upper_zero;
        flags_out[7:5] == 3'h0;
    endproperty
    a_upper_zero: assert property (p_upper_zero) else $error("upper flag bits not zero");
    property p_flag_write;
        $rose(s_axi_bvalid_out) && aw_ff == alu_flag_pkg::FLAG_REG_OFFSET && wd_ff[5]
            |-> flags_out == {3'h0, wd_ff[4:0]};
    endproperty
    a_flag_write: assert property (p_flag_write) else $error("flag write not applied");
    property p_bresp;
        $rose(s_axi_bvalid_out) && (aw_bad || aw_rw) |-> s_axi_bresp_out == (aw_bad ? 2'b10 : 2'b00);
    endproperty
    a_bresp: assert property (p_bresp) else $error("write response code wrong");
    property p_b_latency;
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out |-> ##2 s_axi_bvalid_out;
    endproperty
    a_b_latency: assert property (p_b_latency) else $error("write response late");
    property p_flag_read;
        $rose(s_axi_rvalid_out) && $past(s_axi_araddr_in) == alu_flag_pkg::FLAG_REG_OFFSET
            |-> s_axi_rdata_out == {24'h0, $past(flags_out)};
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read data wrong");
    property p_rdata_hi;
        s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h0;
    endproperty
    a_rdata_hi: assert property (p_rdata_hi) else $error("read data upper bits set");
    property p_w_block;
        s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out;
    endproperty
    a_w_block: assert property (p_w_block) else $error("write taken while response pending");
    property p_r_block;
        s_axi_rvalid_out |-> !s_axi_arready_out;
    endproperty
    a_r_block: assert property (p_r_block) else $error("read taken while data pending");
    property p_flags_quiet;
        $changed(flags_out) |-> $rose(s_axi_bvalid_out);
    endproperty
    a_flags_quiet: assert property (p_flags_quiet) else $error("flags changed without a write");
endmodule
bind alu_status_flag_logic alu_status_flag_checker u_alu_status_flag_checker (
    .clk_in(clk_in), .srst_in(srst_in), .s_axi_awaddr_in(s_axi_awaddr_in), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_awready_out(s_axi_awready_out), .s_axi_wdata_in(s_axi_wdata_in), .s_axi_wstrb_in(s_axi_wstrb_in),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out), .s_axi_bresp_out(s_axi_bresp_out),
    .s_axi_bvalid_out(s_axi_bvalid_out), .s_axi_araddr_in(s_axi_araddr_in),
    .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
    .s_axi_rvalid_out(s_axi_rvalid_out), .flags_out(flags_out));
`default_nettype wire

//--- dv/alu_status_flag_logic_test.sv
`default_nettype none
module alu_status_flag_logic_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_in = 1'b0;
    logic        srst_in = 1'b1;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    wire logic   awready, wready, bvalid, arready, rvalid;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire logic [7:0]  flags;
    int          miscompares = 0;
    int          n_tests = 0;
    logic [4:0]  flg;
    logic [12:0] m;
    logic [7:0]  a_v, b_v, res_v;
    logic [2:0]  ix_v;
    logic        dst_v;
    logic [3:0]  op_v;
    always #12.5 clk_in = ~clk_in;
    alu_status_flag_logic u_alu_status_flag_logic (
        .clk_in(clk_in), .srst_in(srst_in), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
        .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .flags_out(flags));
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic bail();
        miscompares++;
        conclude();
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int   n;
        logic da, dw;
        @(posedge clk_in);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        da = 1'b0;
        dw = 1'b0;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
            da = da | (awvalid && awready === 1'b1);
            dw = dw | (wvalid && wready === 1'b1);
            @(posedge clk_in);
            if (da)
                awvalid <= 1'b0;
            if (dw)
                wvalid <= 1'b0;
        end while (!(da && dw) && n < 50);
        do begin
            @(negedge clk_in);
            n++;
        end while (bvalid !== 1'b1 && n < 100);
        if (bvalid !== 1'b1)
            bail();
        chk("bresp", {30'h0, bresp}, {30'h0, er});
        @(posedge clk_in);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
        int   n;
        logic ok;
        @(posedge clk_in);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(negedge clk_in);
            n++;
            ok = rvalid === 1'b1;
            if (!ok && arvalid && arready === 1'b1) begin
                @(posedge clk_in);
                arvalid <= 1'b0;
            end
        end while (!ok && n < 50);
        if (!ok)
            bail();
        chk(nm, rdata, exp);
        chk("rresp", {30'h0, rresp}, 32'h0);
        @(posedge clk_in);
        rready <= 1'b0;
    endtask
    // Reference flags {N, OV, Z, DC, C}; subtraction adds the inverted subtrahend plus one
    function automatic logic [12:0] model(input logic [3:0] op, input logic [7:0] a, input logic [7:0] b,
                                          input logic [2:0] ix, input logic [4:0] f);
        logic [8:0] s;
        logic [4:0] h, o;
        logic [7:0] bb, r;
        bb = (op == 4'h2 || op == 4'h3) ? ~b : b;
        s = {1'b0, a} + {1'b0, bb} + {8'h00, op[1]};
        h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, op[1]};
        o = f;
        case (op)
            4'h4: r = a & b;
            4'h5: r = a | b;
            4'h6: r = a ^ b;
            4'h7: r = 8'h00;
            4'h8: r = a & ~(8'h01 << ix);
            4'h9: r = a | (8'h01 << ix);
            4'ha: r = {a[3:0], a[7:4]};
            4'hb: r = a;
            4'hc: r = b;
            default: r = s[7:0];
        endcase
        if (op < 4'h4)
            o = {r[7], a[7] == bb[7] && r[7] != a[7], r == 8'h00, h[4], s[8]};
        if (op >= 4'h4 && op <= 4'h6)
            o = {r[7], f[3], r == 8'h00, f[1:0]};
        if (op == 4'h7)
            o = f | 5'h04;
        return {r, o};
    endfunction
    initial begin
        repeat (8) @(posedge clk_in);
        srst_in <= 1'b0;
        rd(alu_flag_pkg::FLAG_REG_OFFSET, 32'h0, "flag reset");
        wr(alu_flag_pkg::FLAG_REG_OFFSET, 32'hffff_ffff, 2'b00);
        rd(alu_flag_pkg::FLAG_REG_OFFSET, 32'h1f, "flag write");
        wr(8'h14, 32'h0, 2'b10);
        rd(alu_flag_pkg::FLAG_REG_OFFSET, 32'h1f, "flag after bad write");
        rd(alu_flag_pkg::CMD_OFFSET, 32'h0, "command readback");
        for (int op = 0; op < 13; op++) begin
            for (int k = 0; k < 4; k++) begin
                op_v = op[3:0];
                dst_v = k[1];
                if (!(dst_v && (op == 1 || op == 2))) begin
                    a_v = k[0] ? 8'h7f : 8'h78;
                    b_v = k[0] ? 8'h01 : 8'h88;
                    ix_v = k[0] ? 3'd7 : 3'd2;
                    flg = k[0] ? 5'h15 : 5'h0a;
                    wr(alu_flag_pkg::FLAG_REG_OFFSET, {27'h0, flg}, 2'b00);
                    wr(alu_flag_pkg::OP_A_OFFSET, {24'h0, a_v}, 2'b00);
                    wr(alu_flag_pkg::OP_B_OFFSET, {24'h0, b_v}, 2'b00);
                    m = model(op_v, dst_v ? {3'h0, flg} : a_v, b_v, ix_v, flg);
                    wr(alu_flag_pkg::CMD_OFFSET, {21'h0, ix_v, 3'h0, dst_v, op_v}, 2'b00);
                    if (!dst_v)
                        res_v = m[12:5];
                    flg = (dst_v && op_v >= 4'h8) ? m[9:5] : m[4:0];
                    rd(alu_flag_pkg::RESULT_OFFSET, {24'h0, res_v}, "result");
                    rd(alu_flag_pkg::FLAG_REG_OFFSET, {27'h0, flg}, "flags");
                    chk("flags_out", {24'h0, flags}, {27'h0, flg});
                end
            end
        end
        // An undefined op code aimed at the flag register leaves everything as it was
        wr(alu_flag_pkg::CMD_OFFSET, 32'h0000_001f, 2'b00);
        rd(alu_flag_pkg::FLAG_REG_OFFSET, {27'h0, flg}, "flags after unknown op");
        rd(alu_flag_pkg::RESULT_OFFSET, {24'h0, res_v}, "result after unknown op");
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clk_in);
        bail();
    end
endmodule
`default_nettype wire
